// ### common/afz_params.svh
// afz_params.svh: offsets, field positions, reset values and timing counts
// of the auto fan zone control block.
// assumes a 125 MHz core clock and an 8-bit register address space.
`ifndef AFZ_PARAMS_SVH
`define AFZ_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define AFZ_ADDR_RANGE1 8'h5F
`define AFZ_ADDR_RANGE2 8'h60
`define AFZ_ADDR_RANGE3 8'h61
`define AFZ_ADDR_BLS_Z1 8'h62
`define AFZ_ADDR_Z2_Z3 8'h63
`define AFZ_ADDR_MIN1 8'h64
`define AFZ_ADDR_MIN2 8'h65
`define AFZ_ADDR_MIN3 8'h66
`define AFZ_ADDR_LIM1 8'h67
`define AFZ_ADDR_LIM2 8'h68
`define AFZ_ADDR_LIM3 8'h69

// ****************************************
// reset values and writable-bit masks
// ****************************************
`define AFZ_RST_RANGE 8'hC4
`define AFZ_RST_BLS_Z1 8'h00
`define AFZ_RST_Z2_Z3 8'h00
`define AFZ_RST_MIN 8'h80
`define AFZ_RST_LIM 8'h5A
`define AFZ_MASK_RANGE 8'hF7
`define AFZ_MASK_BLS_Z1 8'hEF

// ****************************************
// field positions
// ****************************************
`define AFZ_RANGE_MSB 7
`define AFZ_RANGE_LSB 4
`define AFZ_BLS_FAN1_BIT 5
`define AFZ_Z1_EN_BIT 3
`define AFZ_Z2_EN_BIT 7
`define AFZ_Z3_EN_BIT 3
`define AFZ_Z1_TIME_LSB 0
`define AFZ_Z2_TIME_LSB 4
`define AFZ_Z3_TIME_LSB 0

// ****************************************
// range spans in sixths of a degree, codes 0 to 15
// ****************************************
`define AFZ_SPAN6_TABLE {9'h1E0, 9'h140, 9'h0F0, 9'h0C0, 9'h0A0, 9'h078, 9'h060, 9'h050, \
                         9'h03C, 9'h030, 9'h028, 9'h01E, 9'h018, 9'h014, 9'h00F, 9'h00C}
`define AFZ_SPAN_SCALE 11'h006
`define AFZ_DUTY_FULL 8'hFF

// ****************************************
// smoothing timing
// ****************************************
`define AFZ_CLK_KHZ 125000
`define AFZ_SMOOTH_SHIFT 8
// windows in tenths of a second for codes 0 to 7
`define AFZ_WIN0_DS 350
`define AFZ_WIN1_DS 176
`define AFZ_WIN2_DS 118
`define AFZ_WIN3_DS 70
`define AFZ_WIN4_DS 44
`define AFZ_WIN5_DS 30
`define AFZ_WIN6_DS 16
`define AFZ_WIN7_DS 8
// cycles between filter steps: window spread over 2**shift steps, rounded down
`define AFZ_STEP_CYC(ds) (32'(64'(ds) * 64'(`AFZ_CLK_KHZ) * 64'd100 / (64'd1 << `AFZ_SMOOTH_SHIFT)))

`endif

// ### common/afz_pkg.sv
// afz_pkg: types of the auto fan zone control block.
// assumes afz_params.svh supplies the numbers.
package afz_pkg;

   // effective per-zone settings, one per zone/fan pair
   typedef struct packed {
      logic [3:0] range_sel;
      logic smooth_en;
      logic [2:0] smooth_time;
      logic [7:0] limit;
      logic below_sel;
      logic [7:0] min_duty;
   } afz_zone_cfg_t;

   typedef logic [8:0] afz_span_t;

   typedef enum logic [0:0] {
      AFZ_SM_TRACK = 1'b0,
      AFZ_SM_RUN = 1'b1
   } afz_sm_state_t;

endpackage : afz_pkg

// ### logic/afz_smoother.sv
// afz_smoother: low-pass average of one zone's control temperature.
// assumes temp_in is a signed whole-degree sample on the same clock.
`timescale 1ns/1ps
`include "afz_params.svh"

module afz_smoother #(
   parameter logic [7:0][31:0] STEP_CYC = '0
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic [2:0] time_sel,
   input wire logic [7:0] temp_in,
   output logic [7:0] temp_out
);

   afz_pkg::afz_sm_state_t state_q;
   afz_pkg::afz_sm_state_t state_d;
   logic [31:0] cnt_q;
   logic [23:0] acc_q;
   logic [23:0] acc_d;
   logic [24:0] diff;
   logic [24:0] diff_shr;
   wire logic [31:0] step_lim = STEP_CYC[time_sel];
   wire logic tick = (cnt_q >= step_lim);
   wire logic [23:0] sample = {temp_in, 16'h0000};
   // rounded, not cut: an average rising toward a steady reading stalls just below it
   wire logic [7:0] avg_round = acc_q[23:16] + {7'h00, acc_q[15]};

   // one filter step moves the average 1/256 of the way to the sample
   assign diff = {sample[23], sample} - {acc_q[23], acc_q};
   assign diff_shr = $signed(diff) >>> `AFZ_SMOOTH_SHIFT;
   assign state_d = enable ? afz_pkg::AFZ_SM_RUN : afz_pkg::AFZ_SM_TRACK;

   // ****************************************
   // filter state
   // ****************************************
   always_comb
   begin
      acc_d = acc_q;
      case (state_q)
         afz_pkg::AFZ_SM_TRACK: acc_d = sample;
         afz_pkg::AFZ_SM_RUN: if (tick) acc_d = acc_q + diff_shr[23:0];
         default: acc_d = sample;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= afz_pkg::AFZ_SM_TRACK;
         cnt_q <= 32'h00000000;
         acc_q <= 24'h000000;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= (tick || !enable) ? 32'h00000000 : cnt_q + 32'h00000001;
         acc_q <= acc_d;
      end
   end

   // disabled: the averaging path is bypassed entirely
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         temp_out <= 8'h00;
      else
         temp_out <= enable ? avg_round : temp_in;
   end

endmodule : afz_smoother

// ### logic/afz_zone_ctrl.sv
// afz_zone_ctrl: per-zone fan settings and autonomous duty computation.
// assumes the serial register engine, lock/start bits and zone temperatures
// all arrive on clk; fan n is driven from zone n.
`timescale 1ns/1ps
`include "afz_params.svh"

module afz_zone_ctrl #(
   parameter logic [7:0][31:0] SMOOTH_STEP_CYC = {
      `AFZ_STEP_CYC(`AFZ_WIN7_DS),
      `AFZ_STEP_CYC(`AFZ_WIN6_DS),
      `AFZ_STEP_CYC(`AFZ_WIN5_DS),
      `AFZ_STEP_CYC(`AFZ_WIN4_DS),
      `AFZ_STEP_CYC(`AFZ_WIN3_DS),
      `AFZ_STEP_CYC(`AFZ_WIN2_DS),
      `AFZ_STEP_CYC(`AFZ_WIN1_DS),
      `AFZ_STEP_CYC(`AFZ_WIN0_DS)
   }
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   output logic [7:0] reg_rd_data,
   input wire logic cfg_lock,
   input wire logic cfg_start,
   input wire logic [2:0][7:0] zone_temp,
   output logic [2:0][7:0] fan_duty,
   output logic [2:0] fan_pwm
);

   // ****************************************
   // register decode
   // ****************************************
   // while cfg_lock is high no register in this block can be written; writes resume once it falls
   wire logic wr_ok = reg_wr_en && !cfg_lock;

   wire logic [7:0] addr_range [3] = '{`AFZ_ADDR_RANGE1, `AFZ_ADDR_RANGE2, `AFZ_ADDR_RANGE3};
   wire logic [7:0] addr_min [3] = '{`AFZ_ADDR_MIN1, `AFZ_ADDR_MIN2, `AFZ_ADDR_MIN3};
   wire logic [7:0] addr_lim [3] = '{`AFZ_ADDR_LIM1, `AFZ_ADDR_LIM2, `AFZ_ADDR_LIM3};

   wire logic hit_bls_z1 = (reg_addr == `AFZ_ADDR_BLS_Z1);
   wire logic hit_z2_z3 = (reg_addr == `AFZ_ADDR_Z2_Z3);
   logic [2:0] hit_range;
   logic [2:0] hit_min;
   logic [2:0] hit_lim;

   // ****************************************
   // stored registers
   // ****************************************
   logic [2:0][7:0] range_q;
   logic [2:0][7:0] min_q;
   logic [2:0][7:0] lim_q;
   logic [7:0] bls_z1_q;
   logic [7:0] z2_z3_q;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bls_z1_q <= `AFZ_RST_BLS_Z1;
         z2_z3_q <= `AFZ_RST_Z2_Z3;
      end
      else
      begin
         // bit 4 is reserved: never stored, reads as zero
         if (wr_ok && hit_bls_z1)
            bls_z1_q <= reg_wr_data & `AFZ_MASK_BLS_Z1;
         if (wr_ok && hit_z2_z3)
            z2_z3_q <= reg_wr_data;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_regs
         assign hit_range[gi] = (reg_addr == addr_range[gi]);
         assign hit_min[gi] = (reg_addr == addr_min[gi]);
         assign hit_lim[gi] = (reg_addr == addr_lim[gi]);

         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               range_q[gi] <= `AFZ_RST_RANGE;
               min_q[gi] <= `AFZ_RST_MIN;
               lim_q[gi] <= `AFZ_RST_LIM;
            end
            else
            begin
               if (wr_ok && hit_range[gi])
                  range_q[gi] <= reg_wr_data & `AFZ_MASK_RANGE;
               if (wr_ok && hit_min[gi])
                  min_q[gi] <= reg_wr_data;
               if (wr_ok && hit_lim[gi])
                  lim_q[gi] <= reg_wr_data;
            end
         end
      end
   endgenerate

   // ****************************************
   // read path
   // ****************************************
   // reads always show the stored bytes, even while defaults are in force
   wire logic [7:0] rd_mux =
      hit_range[0] ? range_q[0] :
      hit_range[1] ? range_q[1] :
      hit_range[2] ? range_q[2] :
      hit_bls_z1 ? bls_z1_q :
      hit_z2_z3 ? z2_z3_q :
      hit_min[0] ? min_q[0] :
      hit_min[1] ? min_q[1] :
      hit_min[2] ? min_q[2] :
      hit_lim[0] ? lim_q[0] :
      hit_lim[1] ? lim_q[1] :
      hit_lim[2] ? lim_q[2] :
      8'h00;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         reg_rd_data <= 8'h00;
      else
         reg_rd_data <= rd_mux;
   end

   // ****************************************
   // effective settings
   // ****************************************
   // start clear: control uses the reset defaults, not the stored bytes
   wire logic [7:0] eff_bls_z1 = cfg_start ? bls_z1_q : `AFZ_RST_BLS_Z1;
   wire logic [7:0] eff_z2_z3 = cfg_start ? z2_z3_q : `AFZ_RST_Z2_Z3;
   wire logic [7:0] eff_range [3];
   wire logic [7:0] eff_min [3];
   wire logic [7:0] eff_lim [3];

   wire logic [2:0] eff_sm_en = {
      eff_z2_z3[`AFZ_Z3_EN_BIT],
      eff_z2_z3[`AFZ_Z2_EN_BIT],
      eff_bls_z1[`AFZ_Z1_EN_BIT]
   };
   wire logic [2:0][2:0] eff_sm_time = {
      eff_z2_z3[`AFZ_Z3_TIME_LSB +: 3],
      eff_z2_z3[`AFZ_Z2_TIME_LSB +: 3],
      eff_bls_z1[`AFZ_Z1_TIME_LSB +: 3]
   };

   afz_pkg::afz_zone_cfg_t zcfg [3];

   // packed so the table macro reads code 15 down to code 0, left to right
   wire afz_pkg::afz_span_t [15:0] span6_tab = `AFZ_SPAN6_TABLE;

   // ****************************************
   // per-zone smoothing and duty
   // ****************************************
   logic [2:0][7:0] ctl_temp;
   logic [7:0] pwm_cnt_q;

   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_zone
         logic signed [8:0] delta;
         logic [10:0] scaled;
         logic [7:0] headroom;
         logic [18:0] ramp_num;
         logic [18:0] ramp_q;
         logic [8:0] ramp_sum;
         logic below;
         logic full;
         logic [7:0] duty_d;
         afz_pkg::afz_span_t span6;

         assign eff_range[gi] = cfg_start ? range_q[gi] : `AFZ_RST_RANGE;
         assign eff_min[gi] = cfg_start ? min_q[gi] : `AFZ_RST_MIN;
         assign eff_lim[gi] = cfg_start ? lim_q[gi] : `AFZ_RST_LIM;

         assign zcfg[gi].range_sel = eff_range[gi][`AFZ_RANGE_MSB:`AFZ_RANGE_LSB];
         assign zcfg[gi].smooth_en = eff_sm_en[gi];
         assign zcfg[gi].smooth_time = eff_sm_time[gi];
         assign zcfg[gi].limit = eff_lim[gi];
         assign zcfg[gi].below_sel = eff_bls_z1[`AFZ_BLS_FAN1_BIT + gi];
         assign zcfg[gi].min_duty = eff_min[gi];

         // smoothed copy stays local: temperature readings elsewhere stay raw
         afz_smoother #(
            .STEP_CYC(SMOOTH_STEP_CYC)
         ) u_smooth (
            .clk(clk),
            .rst_b(rst_b),
            .enable(zcfg[gi].smooth_en),
            .time_sel(zcfg[gi].smooth_time),
            .temp_in(zone_temp[gi]),
            .temp_out(ctl_temp[gi])
         );

         // signed compare of control temperature against the limit
         assign delta = $signed({ctl_temp[gi][7], ctl_temp[gi]})
                      - $signed({zcfg[gi].limit[7], zcfg[gi].limit});
         assign below = delta[8];

         // work in sixths of a degree so every span is a whole number
         assign span6 = span6_tab[zcfg[gi].range_sel];
         assign scaled = 11'(delta[7:0]) * `AFZ_SPAN_SCALE;
         assign full = (scaled >= 11'(span6));

         assign headroom = `AFZ_DUTY_FULL - zcfg[gi].min_duty;
         assign ramp_num = 19'(headroom) * 19'(scaled);
         // one divider per fan; spans are short so it settles in a cycle
         assign ramp_q = ramp_num / 19'(span6);
         assign ramp_sum = 9'(zcfg[gi].min_duty) + ramp_q[8:0];

         assign duty_d = below ? (zcfg[gi].below_sel ? zcfg[gi].min_duty : 8'h00) :
                         full ? `AFZ_DUTY_FULL :
                         ramp_sum[7:0];

         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               fan_duty[gi] <= 8'h00;
               fan_pwm[gi] <= 1'b0;
            end
            else
            begin
               fan_duty[gi] <= duty_d;
               // high for duty of every 255 counts: FFh is steadily on
               fan_pwm[gi] <= (pwm_cnt_q < fan_duty[gi]);
            end
         end
      end
   endgenerate

   // ****************************************
   // pwm period counter
   // ****************************************
   // 255 steps per period so that value/255 is the exact on-fraction
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         pwm_cnt_q <= 8'h00;
      else if (pwm_cnt_q == (`AFZ_DUTY_FULL - 8'h01))
         pwm_cnt_q <= 8'h00;
      else
         pwm_cnt_q <= pwm_cnt_q + 8'h01;
   end

endmodule : afz_zone_ctrl

// ### verification/afz_zone_ctrl_chk.sv
// afz_zone_ctrl_chk: port assertions for the zone control block.
// assumes it is bound into every afz_zone_ctrl instance.
`timescale 1ns/1ps
`include "afz_params.svh"

module afz_zone_ctrl_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_data,
   input wire logic cfg_lock,
   input wire logic cfg_start,
   input wire logic [2:0][7:0] zone_temp,
   input wire logic [2:0][7:0] fan_duty,
   input wire logic [2:0] fan_pwm
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // ****
   // register side
   // ****
   chk_rd_unmapped: assert property (((reg_addr < 8'h5F) || (reg_addr > 8'h69)) |=> reg_rd_data == 8'h00)
      else $error("unmapped read not zero");
   chk_wr_readback: assert property ((!cfg_lock && reg_wr_en && reg_addr == `AFZ_ADDR_LIM1) ##1
      (reg_addr == `AFZ_ADDR_LIM1 && !reg_wr_en) |=> reg_rd_data == $past(reg_wr_data, 2))
      else $error("limit write not read back");
   chk_lock_hold: assert property ((cfg_lock && reg_wr_en) ##1 (!reg_wr_en && $stable(reg_addr))
      |=> $stable(reg_rd_data))
      else $error("locked write changed contents");
   chk_res_bit: assert property ((reg_addr == `AFZ_ADDR_BLS_Z1) |=> !reg_rd_data[4])
      else $error("reserved bit reads one");
   chk_range_bit: assert property ((reg_addr inside {`AFZ_ADDR_RANGE1, `AFZ_ADDR_RANGE2, `AFZ_ADDR_RANGE3})
      |=> !reg_rd_data[3])
      else $error("range bit 3 reads one");

   // ****
   // duty and pwm side
   // ****
   chk_pwm_full: assert property ((fan_duty[0] == 8'hFF) |=> fan_pwm[0])
      else $error("full duty pwm low");
   chk_pwm_zero: assert property ((fan_duty[1] == 8'h00) |=> !fan_pwm[1])
      else $error("zero duty pwm high");
   chk_pwm_full_fan3: assert property ((fan_duty[2] == 8'hFF) |=> fan_pwm[2])
      else $error("full duty pwm low on fan 3");
   chk_default_min: assert property ((!cfg_start && zone_temp[0] == 8'h5A) [*5] |-> fan_duty[0] == 8'h80)
      else $error("default minimum duty wrong");
   chk_default_off: assert property ((!cfg_start && zone_temp[1] == 8'h59) [*5] |-> fan_duty[1] == 8'h00)
      else $error("default below-limit duty wrong");
   chk_default_full: assert property ((!cfg_start && zone_temp[2] == 8'h7F) [*5] |-> fan_duty[2] == 8'hFF)
      else $error("default full duty wrong");
endmodule : afz_zone_ctrl_chk

bind afz_zone_ctrl afz_zone_ctrl_chk i_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
   .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .cfg_lock(cfg_lock), .cfg_start(cfg_start),
   .zone_temp(zone_temp), .fan_duty(fan_duty), .fan_pwm(fan_pwm));

// ### verification/afz_fan_model.sv
// afz_fan_model: a fan on one pwm pin, counting its on-clocks.
// assumes measure is a one-clock pulse and the pwm period is 255 clocks.
`timescale 1ns/1ps

module afz_fan_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pwm,
   input wire logic measure,
   output logic [7:0] seen_duty
);
   logic [7:0] cnt_q;
   logic [7:0] acc_q;

   // ****
   // window of one full period, so the start phase does not matter
   // ****
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_q <= 8'h00;
         acc_q <= 8'h00;
      end
      else if (measure)
      begin
         cnt_q <= 8'hFF;
         acc_q <= 8'h00;
      end
      else if (cnt_q != 8'h00)
      begin
         cnt_q <= cnt_q - 8'h01;
         acc_q <= acc_q + {7'h00, pwm};
      end
   end
   assign seen_duty = acc_q;
endmodule : afz_fan_model

// ### verification/afz_zone_ctrl_tb.sv
// afz_zone_ctrl_tb: self-checking bench, fan model on fan 1.
// assumes afz_params.svh and afz_pkg are compiled first.
`timescale 1ns/1ps
`include "afz_params.svh"

module afz_zone_ctrl_tb;
   typedef struct {int sel; logic [7:0] exp;} afz_note_t;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr_en = 1'b0;
   logic [7:0] reg_wr_data = 8'h00;
   logic cfg_lock = 1'b0;
   logic cfg_start = 1'b0;
   logic [2:0][7:0] zone_temp = {8'h7F, 8'h59, 8'h5A};
   logic measure = 1'b0;
   logic [7:0] reg_rd_data;
   logic [2:0][7:0] fan_duty;
   logic [2:0] fan_pwm;
   logic [7:0] seen_duty;
   afz_note_t notes[$];
   event chk_ev;
   int failures = 0;
   int tests_run = 0;
   int span6 [16] = '{12, 15, 20, 24, 30, 40, 48, 60, 80, 96, 120, 160, 192, 240, 320, 480};
   logic [7:0] rst_tab [11] = '{8'hC4, 8'hC4, 8'hC4, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A};

   always #4 clk = ~clk;

   afz_zone_ctrl #(.SMOOTH_STEP_CYC({8{32'd4}})) i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .cfg_lock(cfg_lock),
      .cfg_start(cfg_start), .zone_temp(zone_temp), .fan_duty(fan_duty), .fan_pwm(fan_pwm));
   afz_fan_model i_fan (.clk(clk), .rst_b(rst_b), .pwm(fan_pwm[0]), .measure(measure), .seen_duty(seen_duty));

   // ****
   // shared tasks
   // ****
   task check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task end_sim;
      $display("checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task note(input int sel, input logic [7:0] exp);
      notes.push_back('{sel, exp});
      -> chk_ev;
   endtask : note

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      @(negedge clk);
      reg_wr_en = 1'b0;
   endtask : wr

   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      note(0, e);
   endtask : rd_chk

   // duty lands two edges after a temperature change, one after a setting
   task duty_chk(input int z, input logic [7:0] e);
      repeat (3) @(negedge clk);
      note(z + 1, e);
   endtask : duty_chk

   function automatic logic [7:0] exp_duty(input int t, input int l, input int code, input int mn, input int bs);
      int d6;
      if (t < l)
         return bs ? 8'(mn) : 8'h00;
      d6 = 6 * (t - l);
      if (d6 >= span6[code])
         return 8'hFF;
      return 8'(mn + (255 - mn) * d6 / span6[code]);
   endfunction : exp_duty

   // ****
   // result monitor
   // ****
   initial
   begin : mon
      afz_note_t n;
      forever
      begin
         @(chk_ev);
         n = notes.pop_front();
         if (n.sel == 0)
            check(reg_rd_data, n.exp);
         else if (n.sel == 4)
            check(seen_duty, n.exp);
         else
            check(fan_duty[n.sel - 1], n.exp);
      end
   end

   initial
   begin
      #(8 * 30000);
      failures++;
      end_sim;
   end

   // ****
   // main sequence
   // ****
   initial
   begin : main
      int code, mn, lim, tmp;
      logic [2:0] bs;
      logic [7:0] e0;
      void'($urandom(243));
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      for (int a = 0; a < 11; a++)
         rd_chk(8'h5F + 8'(a), rst_tab[a]);
      rd_chk(8'h70, 8'h00);
      duty_chk(0, 8'h80);
      duty_chk(1, 8'h00);
      duty_chk(2, 8'hFF);
      wr(`AFZ_ADDR_MIN1, 8'h40);
      rd_chk(`AFZ_ADDR_MIN1, 8'h40);
      duty_chk(0, 8'h80);
      cfg_start = 1'b1;
      duty_chk(0, 8'h40);
      wr(`AFZ_ADDR_BLS_Z1, 8'hFF);
      rd_chk(`AFZ_ADDR_BLS_Z1, 8'hEF);
      duty_chk(1, 8'h80);
      wr(`AFZ_ADDR_BLS_Z1, 8'h00);
      wr(`AFZ_ADDR_RANGE1, 8'hFF);
      rd_chk(`AFZ_ADDR_RANGE1, 8'hF7);
      cfg_lock = 1'b1;
      wr(`AFZ_ADDR_LIM1, 8'h11);
      rd_chk(`AFZ_ADDR_LIM1, 8'h5A);
      cfg_lock = 1'b0;
      for (int it = 0; it < 16; it++)
      begin
         bs = 3'($urandom);
         wr(`AFZ_ADDR_BLS_Z1, {bs, 5'h00});
         for (int z = 0; z < 3; z++)
         begin
            code = (it + z) % 16;
            mn = $urandom_range(0, 255);
            lim = int'($urandom_range(0, 90)) - 60;
            tmp = lim + int'($urandom_range(0, 90)) - 10;
            wr(8'h5F + 8'(z), {4'(code), 4'h4});
            wr(8'h64 + 8'(z), 8'(mn));
            wr(8'h67 + 8'(z), 8'(lim));
            @(negedge clk);
            zone_temp[z] = 8'(tmp);
            if (z == 0)
               e0 = exp_duty(tmp, lim, code, mn, bs[z]);
            duty_chk(z, exp_duty(tmp, lim, code, mn, bs[z]));
         end
      end
      @(negedge clk);
      measure = 1'b1;
      @(negedge clk);
      measure = 1'b0;
      repeat (256) @(negedge clk);
      note(4, e0);
      for (int z = 0; z < 3; z++)
      begin
         wr(8'h5F + 8'(z), 8'hC4);
         wr(8'h64 + 8'(z), 8'h80);
         wr(8'h67 + 8'(z), 8'h5A);
         zone_temp[z] = 8'h5A;
      end
      // every zone smoothed, as software should do for processor-side sensors
      wr(`AFZ_ADDR_BLS_Z1, 8'h08);
      wr(`AFZ_ADDR_Z2_Z3, 8'h88);
      rd_chk(`AFZ_ADDR_Z2_Z3, 8'h88);
      // the step comes only after every filter has reloaded from the old reading
      zone_temp = {3{8'h7F}};
      for (int z = 0; z < 3; z++)
         duty_chk(z, 8'h80);
      wr(`AFZ_ADDR_BLS_Z1, 8'h00);
      wr(`AFZ_ADDR_Z2_Z3, 8'h00);
      for (int z = 0; z < 3; z++)
         duty_chk(z, 8'hFF);
      // let the monitor take the last note before the verdict
      @(negedge clk);
      end_sim;
   end
endmodule : afz_zone_ctrl_tb
